// file: src/deep_sleep_timer.sv
// Deep-sleep entry and exit timer with a classic Wishbone register slave
//
// Chosen here: the register addresses and the Wishbone register port.
module deep_sleep_timer
  import sleep_timer_pkg::*;
#(
  parameter int SLEEP_CLK_HZ = 32768
) (
  input  wire  logic        clk_sys,
  input  wire  logic        rst_n,
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire  logic        sleep_clock,
  input  wire  logic        radio_domain_up,
  input  wire  logic [15:0] em_offset,
  output logic [31:0]       em_addr,
  output logic              wake_irq,
  output logic              sleep_exit_irq,
  output logic              radio_off_permit,
  output logic              core_clk_enable,
  output logic              radio_sleep,
  output logic              slot_tick,
  output logic              irq
);

  // ****************************************************************
  // Elaboration checks and derived constants
  // ****************************************************************
  // Tick period is exact for the 32000 and 10000 Hz sleep clocks and rounds down at 32768 Hz
  if (SLEEP_CLK_HZ != 32000 && SLEEP_CLK_HZ != 32768
      && SLEEP_CLK_HZ != 10000) begin : g_bad_rate
    $error("unsupported sleep clock rate");
  end
  localparam logic [31:0] TICK_NS  = 32'(1000000000 / SLEEP_CLK_HZ);
  localparam logic [31:0] SYS_NS   = 32'(CLK_SYS_NS);
  localparam logic [31:0] SLOT_LIM = 32'(SLOT_NS);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic       rst_s1_ff, rst_sync_n;
  logic [2:0] sclk_ff;
  logic [1:0] rup_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff  <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_sync_n <= rst_s1_ff;
    end
  end

  // Edge detect reads only the second and third stages
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sclk_ff <= 3'h0;
      rup_ff  <= 2'h0;
    end else begin
      sclk_ff <= {sclk_ff[1:0], sleep_clock};
      rup_ff  <= {rup_ff[0], radio_domain_up};
    end
  end
  wire tick     = sclk_ff[1] & ~sclk_ff[2];
  wire radio_up = rup_ff[1];

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  logic [31:0] ctl_ff, dur_ff, tim_ff, act_ff, mask_ff, base_ff, slot_cnt_ff;
  logic [1:0]  stat_ff;
  state_t      state_ff, nxt_state;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wr_en  = wb_req & wb_we_i & wb_ack_o;
  wire wr_ctl = wr_en && wb_adr_i == OFS_SLEEP_CONTROL;
  wire wr_dur = wr_en && wb_adr_i == OFS_SLEEP_DURATION;
  wire wr_tim = wr_en && wb_adr_i == OFS_WAKE_TIMING;
  wire wr_sts = wr_en && wb_adr_i == OFS_IRQ_STATUS;
  wire wr_msk = wr_en && wb_adr_i == OFS_IRQ_MASK;
  wire wr_emb = wr_en && wb_adr_i == OFS_EXCH_MEM_BASE;

  wire [31:0] ctl_view = {21'h0, state_ff == ST_SLEEP, radio_up, radio_off_permit,
                          3'h0, ctl_ff[4:0]};
  wire [31:0] rd_data =
    (wb_adr_i == OFS_SLEEP_CONTROL)  ? ctl_view :
    (wb_adr_i == OFS_SLEEP_DURATION) ? dur_ff :
    (wb_adr_i == OFS_WAKE_TIMING)    ? tim_ff :
    (wb_adr_i == OFS_ACTUAL_SLEEP)   ? act_ff :
    (wb_adr_i == OFS_IRQ_STATUS)     ? {30'h0, stat_ff} :
    (wb_adr_i == OFS_IRQ_MASK)       ? mask_ff :
    (wb_adr_i == OFS_EXCH_MEM_BASE)  ? base_ff :
    (wb_adr_i == OFS_SLOT_COUNT)     ? slot_cnt_ff : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // ****************************************************************
  // Sleep timer fields
  // ****************************************************************
  wire [31:0] lead    = 32'(tim_ff[TIM_LEAD_LSB +: TIM_FIELD_W]);
  wire [31:0] release_c = 32'(tim_ff[TIM_REL_LSB +: TIM_FIELD_W]);
  wire [31:0] ext_w   = 32'(tim_ff[TIM_EXT_LSB +: TIM_FIELD_W]);
  wire [31:0] ext_hold = (ext_w > release_c) ? ext_w - release_c : 32'h1;

  logic [31:0] cnt_ff, hold_ff, slot_acc_ff;
  logic        expired_ff, wake_seen_ff, ext_hold_on_ff, wake_seen_q;

  wire asleep    = state_ff != ST_ACTIVE;
  wire ext_req   = ctl_ff[CTL_EXT_REQ] & ~ctl_ff[CTL_EXT_DIS];
  // Request bit acts only once asleep and before expiry; written while still awake it only refuses entry and raises no IRQ
  wire ext_event = asleep & ext_req & ~expired_ff & ~ext_hold_on_ff;
  // A request written together with the enter bit refuses entry as well
  wire enter     = wr_ctl & wb_dat_i[CTL_SLEEP_ON] & wb_sel_i[0] & ~wb_dat_i[CTL_EXT_REQ]
                 & ~ctl_ff[CTL_EXT_REQ] & (state_ff == ST_ACTIVE);
  wire [31:0] cnt_nxt = cnt_ff + 32'h1;
  wire        exp_now = cnt_nxt >= dur_ff;
  wire [31:0] remain  = exp_now ? 32'h0 : dur_ff - cnt_nxt;
  wire core_ready = ctl_ff[CTL_CORE_CLK] & radio_up & ~ctl_ff[CTL_RADIO_SLP];
  wire do_exit    = (state_ff == ST_EXIT) & core_ready & wake_seen_ff & ~wake_irq;

  // ****************************************************************
  // Sequence
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ACTIVE: if (enter) nxt_state = ST_SWITCH;
      ST_SWITCH: if (tick) nxt_state = ST_SLEEP;
      ST_SLEEP:  if (expired_ff) nxt_state = ST_EXIT;
      ST_EXIT:   if (do_exit) nxt_state = ST_ACTIVE;
      default:   nxt_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff         <= ST_ACTIVE;
      cnt_ff           <= 32'h0;
      expired_ff       <= 1'b0;
      wake_irq         <= 1'b0;
      wake_seen_ff     <= 1'b0;
      ext_hold_on_ff   <= 1'b0;
      hold_ff          <= 32'h0;
      act_ff           <= 32'h0;
      sleep_exit_irq   <= 1'b0;
      radio_off_permit <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      sleep_exit_irq <= do_exit;
      if (enter) begin
        cnt_ff         <= 32'h0;
        expired_ff     <= 1'b0;
        wake_seen_ff   <= 1'b0;
        ext_hold_on_ff <= 1'b0;
      end else if (ext_event) begin
        wake_irq       <= 1'b1;
        wake_seen_ff   <= 1'b1;
        ext_hold_on_ff <= 1'b1;
        expired_ff     <= 1'b1;
        hold_ff        <= ext_hold;
      end else if (tick && (state_ff == ST_SLEEP || state_ff == ST_EXIT)) begin
        cnt_ff <= cnt_nxt;
        if (ext_hold_on_ff) begin
          hold_ff <= hold_ff - 32'h1;
          if (hold_ff <= 32'h1) wake_irq <= 1'b0;
        end else if (!expired_ff) begin
          expired_ff <= exp_now;
          if (remain <= release_c) wake_irq <= 1'b0;
          else if (remain <= lead) begin
            wake_irq     <= 1'b1;
            wake_seen_ff <= 1'b1;
          end
        end else if (!wake_seen_ff) begin
          // Lead too short for the release window: wake one tick late, sleep runs long
          wake_irq     <= 1'b1;
          wake_seen_ff <= 1'b1;
        end else begin
          // Late wake lasts one tick; exit waits for it to fall
          wake_irq <= 1'b0;
        end
      end
      if (do_exit) act_ff <= cnt_ff;
      if (state_ff == ST_SWITCH && tick) radio_off_permit <= 1'b1;
      else if (do_exit) radio_off_permit <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers, interrupts, exchange memory
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctl_ff  <= RST_CONTROL;
      dur_ff  <= 32'h0;
      tim_ff  <= RST_TIMING;
      mask_ff <= 32'h0;
      base_ff <= RST_EMBASE;
      stat_ff <= 2'h0;
    end else begin
      if (wr_ctl) ctl_ff <= merge(ctl_ff, wb_dat_i, wb_sel_i) & 32'h0000_001e;
      if (enter) ctl_ff[CTL_SLEEP_ON] <= 1'b1;
      else if (do_exit) begin
        ctl_ff[CTL_SLEEP_ON] <= 1'b0;
        ctl_ff[CTL_EXT_REQ]  <= 1'b0;
      end
      if (wr_dur) dur_ff <= merge(dur_ff, wb_dat_i, wb_sel_i);
      if (wr_tim) tim_ff <= merge(tim_ff, wb_dat_i, wb_sel_i) & 32'h3fff_ffff;
      if (wr_msk) mask_ff <= merge(mask_ff, wb_dat_i, wb_sel_i) & 32'h0000_0003;
      if (wr_emb) base_ff <= merge(base_ff, wb_dat_i, wb_sel_i);
      // Hardware set wins over a same-cycle write-one clear
      stat_ff[IRQ_WAKE] <= (wake_irq & ~wake_seen_q) |
                           (stat_ff[IRQ_WAKE] & ~(wr_sts & wb_sel_i[0] & wb_dat_i[IRQ_WAKE]));
      stat_ff[IRQ_EXIT] <= do_exit |
                           (stat_ff[IRQ_EXIT] & ~(wr_sts & wb_sel_i[0] & wb_dat_i[IRQ_EXIT]));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_seen_q <= 1'b0;
      em_addr     <= 32'h0;
    end else begin
      wake_seen_q <= wake_irq;
      em_addr     <= base_ff + {16'h0, em_offset};
    end
  end

  assign irq             = |(stat_ff & mask_ff[1:0]);
  assign core_clk_enable = ctl_ff[CTL_CORE_CLK];
  assign radio_sleep     = ctl_ff[CTL_RADIO_SLP];

  // ****************************************************************
  // Slot reference, seamless across the clock handover
  // ****************************************************************
  wire [31:0] slot_add = asleep ? (tick ? TICK_NS : 32'h0) : SYS_NS;
  wire [31:0] slot_sum = slot_acc_ff + slot_add;
  wire        slot_hit = slot_sum >= SLOT_LIM;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      slot_acc_ff <= 32'h0;
      slot_cnt_ff <= 32'h0;
      slot_tick   <= 1'b0;
    end else begin
      slot_acc_ff <= slot_hit ? slot_sum - SLOT_LIM : slot_sum;
      slot_cnt_ff <= slot_cnt_ff + {31'h0, slot_hit};
      slot_tick   <= slot_hit;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  exit_after_wake_a: assert property (sleep_exit_irq |-> wake_seen_q == 1'b0 && wake_seen_ff)
    else $error("sleep exit without prior wake interrupt");
  exit_needs_ready_a: assert property (sleep_exit_irq |-> $past(core_ready) && $past(expired_ff))
    else $error("sleep exit before core ready");
  refuse_entry_a: assert property (ctl_ff[CTL_EXT_REQ] && state_ff == ST_ACTIVE |=> state_ff != ST_SWITCH)
    else $error("sleep entered with wake request high");
  ext_wake_now_a: assert property (ext_event |=> wake_irq)
    else $error("external wake did not raise interrupt");
  permit_after_switch_a: assert property ($rose(radio_off_permit) |-> state_ff == ST_SLEEP)
    else $error("permit raised before clock handover");
  hold_expired_a: assert property (state_ff == ST_EXIT && !core_ready |=> state_ff == ST_EXIT)
    else $error("left sleep while core down");
  wake_lead_a: assert property (tick && state_ff == ST_SLEEP && !expired_ff && !ext_hold_on_ff
      && !ext_event && remain <= lead && remain > release_c |=> wake_irq)
    else $error("wake interrupt missing at lead");
  wake_release_a: assert property (tick && state_ff == ST_SLEEP && !expired_ff && !ext_hold_on_ff
      && !ext_event && remain <= release_c |=> !wake_irq)
    else $error("wake interrupt not released");
  count_report_a: assert property (sleep_exit_irq |-> act_ff == $past(cnt_ff))
    else $error("actual duration not captured");
  late_wake_a: assert property (tick && state_ff == ST_EXIT && !ext_hold_on_ff && !wake_seen_ff |=> wake_irq)
    else $error("late wake interrupt missing");

endmodule // deep_sleep_timer

// file: src/sleep_timer_pkg.sv
// Constants, register map and states of the deep-sleep timer
// How it works
// - Every sleep exit raises wake interrupt first, then sleep-exit interrupt.
// - Wake interrupt rises lead sleep-clock cycles before the timer expires.
// - A too-short lead still wakes; the measured duration simply grows.
// - Wake interrupt falls release sleep-clock cycles before the sleep period ends.
// - External wake holds wake interrupt for width minus release sleep-clock cycles.
// - Setting the external wake request while asleep and before expiry raises wake interrupt at once.
// - Entering sleep moves the 625 us slot reference onto the sleep clock.
// - Radio-off permit shows the sleep clock has taken over; software polls it.
// - After expiry the timer stays asleep until the core is powered up.
// - Expired, clocks on and radio up: leave sleep and raise sleep-exit interrupt.
// - Exchange memory addresses are base plus a 64 kB offset.
// - Sleep clock runs at 32.0 kHz, 32.768 kHz or 10 kHz.
// - External wake request refuses sleep entry even with the disable bit set; that bit suppresses only its wake.
package sleep_timer_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_SLEEP_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_SLEEP_DURATION = 8'h04;
  localparam logic [7:0] OFS_WAKE_TIMING    = 8'h08;
  localparam logic [7:0] OFS_ACTUAL_SLEEP   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h14;
  localparam logic [7:0] OFS_EXCH_MEM_BASE  = 8'h18;
  localparam logic [7:0] OFS_SLOT_COUNT     = 8'h1c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_SLEEP_ON   = 0;
  localparam int CTL_EXT_DIS    = 1;
  localparam int CTL_EXT_REQ    = 2;
  localparam int CTL_CORE_CLK   = 3;
  localparam int CTL_RADIO_SLP  = 4;
  localparam int CTL_PERMIT     = 8;
  localparam int CTL_RADIO_UP   = 9;
  localparam int CTL_ASLEEP     = 10;
  localparam int TIM_FIELD_W    = 10;
  localparam int TIM_LEAD_LSB   = 0;
  localparam int TIM_REL_LSB    = 10;
  localparam int TIM_EXT_LSB    = 20;
  localparam int IRQ_WAKE       = 0;
  localparam int IRQ_EXIT       = 1;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [31:0] RST_CONTROL = 32'h0000_0008;
  localparam logic [31:0] RST_TIMING  = 32'h0020_0402;
  localparam logic [31:0] RST_EMBASE  = 32'h0000_0000;
  localparam int SLOT_NS      = 625000;
  localparam int CLK_SYS_HZ   = 10000000;
  localparam int CLK_SYS_NS   = 1000000000 / CLK_SYS_HZ;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_SWITCH = 4'b0010,
    ST_SLEEP  = 4'b0100,
    ST_EXIT   = 4'b1000
  } state_t;

endpackage

// file: tb/radio_power_model.sv
// Behavioural model of the radio power domain switched by firmware
module radio_power_model (
  input  wire logic clk_sys,
  input  wire logic radio_sleep,
  output logic      radio_domain_up
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Power switch
  // ****************************************************************
  // Power-up is slow on purpose, so the core waits on the domain
  int up_cnt = 30;
  initial radio_domain_up = 1'b1;
  always @(posedge clk_sys) begin
    if (radio_sleep === 1'b1) begin
      up_cnt <= 0;
      radio_domain_up <= 1'b0;
    end else if (up_cnt < 30) begin
      up_cnt <= up_cnt + 1;
    end else begin
      radio_domain_up <= 1'b1;
    end
  end
endmodule // radio_power_model

// file: tb/testbench.sv
// Self-checking bench for the deep-sleep timer
module testbench;
  import sleep_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slp_clk = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, q, em_addr, q0;
  logic [15:0] em_offset = 0;
  logic ack, wake_irq, sleep_exit_irq, permit, core_clk, radio_sleep, radio_up, slot, irq;
  int fails = 0, samples_checked = 0, exits = 0, hi, slots = 0, slot0;
  // ****************************************************************
  // Clocks, models and design
  // ****************************************************************
  initial forever #50 clk_sys = ~clk_sys;
  // Sleep clock kept fast to shorten the run; only its edges matter
  initial forever #1000 slp_clk = ~slp_clk;
  always @(posedge clk_sys) if (sleep_exit_irq === 1'b1) exits <= exits + 1;
  always @(posedge clk_sys) if (slot === 1'b1) slots <= slots + 1;
  radio_power_model radio_power_model_inst (.clk_sys(clk_sys), .radio_sleep(radio_sleep),
    .radio_domain_up(radio_up));
  deep_sleep_timer deep_sleep_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_clock(slp_clk), .radio_domain_up(radio_up),
    .em_offset(em_offset), .em_addr(em_addr), .wake_irq(wake_irq),
    .sleep_exit_irq(sleep_exit_irq), .radio_off_permit(permit), .core_clk_enable(core_clk),
    .radio_sleep(radio_sleep), .slot_tick(slot), .irq(irq));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      give_verdict();
    end
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? wake_irq : k == 1 ? sleep_exit_irq : permit;
  endfunction
  // Waits for output k to reach v; hi counts the cycles spent
  task automatic wait_sig(input int k, input logic v);
    for (hi = 0; hi < 20000; hi++) begin
      @(posedge clk_sys);
      if (pick(k) === v) return;
    end
    fails++;
    give_verdict();
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    repeat (4) @(posedge clk_sys);
    wb(0, OFS_SLEEP_CONTROL, 0); check(q, RST_CONTROL | 32'h200);
    check(core_clk, 1);
    wb(0, OFS_WAKE_TIMING, 0); check(q, RST_TIMING);
    wb(0, 8'h20, 0); check(q, 0);
    $display("test reset done");
    wb(1, OFS_WAKE_TIMING, 32'h0020_0403);
    wb(1, OFS_SLEEP_DURATION, 32'h8);
    wb(1, OFS_IRQ_MASK, 0);
    wb(1, OFS_SLEEP_CONTROL, 32'h9);
    wait_sig(2, 1);
    wb(1, OFS_SLEEP_CONTROL, 32'h11);
    @(negedge clk_sys);
    check(core_clk, 0);
    check(radio_sleep, 1);
    wait_sig(0, 1);
    check(exits, 0);
    wait_sig(0, 0);
    check(hi >= 30 && hi <= 50, 1);
    repeat (200) @(posedge clk_sys);
    check(exits, 0);
    wb(1, OFS_SLEEP_CONTROL, 32'h9);
    wait_sig(1, 1);
    @(negedge clk_sys);
    check(irq, 0);
    wb(0, OFS_IRQ_STATUS, 0); check(q, 32'h3);
    wb(0, OFS_ACTUAL_SLEEP, 0); check(q >= 32'd12, 1);
    wb(0, OFS_SLEEP_CONTROL, 0); check(q[CTL_ASLEEP], 0);
    wb(1, OFS_IRQ_MASK, 32'h3);
    @(negedge clk_sys);
    check(irq, 1);
    wb(1, OFS_IRQ_STATUS, 32'h3);
    wb(0, OFS_IRQ_STATUS, 0); check(q, 0);
    check(irq, 0);
    $display("test timed sleep done");
    wb(1, OFS_WAKE_TIMING, 32'h0020_0400);
    wb(1, OFS_SLEEP_DURATION, 32'h4);
    wb(1, OFS_SLEEP_CONTROL, 32'hb);
    wait_sig(2, 1);
    wb(1, OFS_SLEEP_CONTROL, 32'hf);
    repeat (5) @(posedge clk_sys);
    check(wake_irq, 0);
    wait_sig(0, 1);
    check(exits, 1);
    wait_sig(0, 0);
    wait_sig(1, 1);
    wb(0, OFS_ACTUAL_SLEEP, 0); check(q > 32'd4, 1);
    wb(0, OFS_IRQ_STATUS, 0); check(q, 32'h3);
    wb(1, OFS_IRQ_STATUS, 32'h3);
    $display("test short lead done");
    wb(1, OFS_SLEEP_CONTROL, 32'h9);
    wait_sig(2, 1);
    wb(1, OFS_SLEEP_CONTROL, 32'hd);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(wake_irq, 1);
    wait_sig(0, 0);
    check(hi <= 30, 1);
    wait_sig(1, 1);
    wb(0, OFS_IRQ_STATUS, 0); check(q, 32'h3);
    wb(1, OFS_IRQ_STATUS, 32'h3);
    $display("test external wake done");
    wb(1, OFS_SLEEP_CONTROL, 32'hd);
    repeat (100) @(posedge clk_sys);
    check(permit, 0);
    wb(1, OFS_SLEEP_CONTROL, 32'h8);
    $display("test refused entry done");
    wb(1, OFS_EXCH_MEM_BASE, 32'h2000_0000);
    em_offset <= 16'hfffe;
    repeat (3) @(posedge clk_sys);
    check(em_addr, 32'h2000_fffe);
    $display("test exchange memory done");
    wb(0, OFS_SLOT_COUNT, 0);
    q0 = q;
    slot0 = slots;
    repeat (6247) @(posedge clk_sys);
    wb(0, OFS_SLOT_COUNT, 0); check(q - q0, 1);
    check(slots - slot0, 1);
    $display("test slot reference done");
    give_verdict();
  end
endmodule // testbench
